// ==== include/iau_defs.vh ====
`ifndef IAU_DEFS_VH
`define IAU_DEFS_VH
// event codes
`define IAU_CODE_NMI 12'h1C0
`define IAU_CODE_IRL_BASE 12'h200
`define IAU_CODE_IRL_STEP 12'h020
`define IAU_CODE_POR 12'h000
// vector offsets and fixed addresses
`define IAU_VEC_INT 32'h00000600
`define IAU_VEC_GEN 32'h00000100
`define IAU_RESET_PC 32'hA0000000
`define IAU_VBR_RST 32'h00000000
// status word field positions
`define IAU_SR_MD 30
`define IAU_SR_RB 29
`define IAU_SR_BL 28
`define IAU_SR_IM_LO 4
`define IAU_SR_IM_HI 7
`define IAU_SR_RST 32'h700000F0
// axi register byte offsets
`define IAU_A_SR 12'h000
`define IAU_A_VBR 12'h004
`define IAU_A_SPC 12'h008
`define IAU_A_SSR 12'h00C
`define IAU_A_EVT 12'h010
`define IAU_A_EVT2 12'h014
`define IAU_A_EXP 12'h018
`define IAU_A_CTL 12'h01C
`define IAU_A_PRIO 12'h020
`define IAU_A_PC 12'h024
// control register bits
`define IAU_CTL_OVR 0
`define IAU_CTL_SLEEP 1
`endif

// ==== rtl/iau_arbiter.v ====
`timescale 1ns/100ps
`include "iau_defs.vh"
// picks highest-level eligible maskable request
module iau_arbiter #(
   parameter N = 8
)(
   // requests
   input wire [N-1:0] req,
   input wire [4*N-1:0] lvl,
   input wire [12*N-1:0] code,
   // winner
   output reg hit,
   output reg [3:0] win_lvl,
   output reg [12*1-1:0] win_code,
   output reg [$clog2(N+1)-1:0] win_idx
);
   integer i;
   always @*
   begin
      hit = 1'b0;
      win_lvl = 4'h0;
      win_code = 12'h000;
      win_idx = {$clog2(N+1){1'b0}};
      for (i = 0; i < N; i = i + 1)
      begin
         // strictly higher wins, lower index keeps ties
         if (req[i] && (!hit || lvl[4*i +: 4] > win_lvl))
         begin
            hit = 1'b1;
            win_lvl = lvl[4*i +: 4];
            win_code = code[12*i +: 12];
            win_idx = i[$clog2(N+1)-1:0];
         end
      end
   end
endmodule

// ==== rtl/iau_sync.v ====
`timescale 1ns/100ps
// two-flop synchroniser per bit
module iau_sync #(
   parameter W = 1
)(
   input wire clk,
   input wire rst_n,
   input wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
      end
   end
   assign q = s2_r;
endmodule

// ==== rtl/iau_top.v ====
`timescale 1ns/100ps
`include "iau_defs.vh"
module iau_top #(
   parameter NPIN = 2,
   parameter NMOD = 4
)(
   // clock and reset
   input wire REF_CLK,
   input wire RESETN,
   // request pins
   input wire NMI_PIN,
   input wire [3:0] IRL_N,
   input wire [NPIN-1:0] PIN_REQ,
   input wire [NMOD-1:0] MOD_REQ,
   input wire [12*NPIN-1:0] PIN_CODE,
   input wire [12*NMOD-1:0] MOD_CODE,
   // pipeline side
   input wire BOUNDARY,
   input wire [31:0] NEXT_PC,
   input wire [31:0] CUR_PC,
   input wire [31:0] BR_PC,
   input wire [31:0] BR_TGT,
   input wire IN_SLOT,
   input wire BR_TAKEN,
   input wire EXC_REQ,
   input wire EXC_REEXEC,
   input wire EXC_UBRK,
   input wire [11:0] EXC_CODE,
   input wire RET_REQ,
   output reg TAKE,
   output reg [31:0] NEW_PC,
   output reg [31:0] SR_OUT,
   // axi4-lite slave
   input wire [11:0] AWADDR,
   input wire AWVALID,
   output reg AWREADY,
   input wire [31:0] WDATA,
   input wire [3:0] WSTRB,
   input wire WVALID,
   output reg WREADY,
   output reg [1:0] BRESP,
   output reg BVALID,
   input wire BREADY,
   input wire [11:0] ARADDR,
   input wire ARVALID,
   output reg ARREADY,
   output reg [31:0] RDATA,
   output reg [1:0] RRESP,
   output reg RVALID,
   input wire RREADY
);
   localparam NM = NPIN + NMOD + 1;
   reg [31:0] sr_r;
   reg [31:0] vbr_r;
   reg [31:0] spc_r;
   reg [31:0] ssr_r;
   reg [11:0] evt_r;
   reg [11:0] evt2_r;
   reg [11:0] exp_r;
   reg [1:0] ctl_r;
   reg [4*NMOD-1:0] prio_r;
   reg [4*NPIN-1:0] pprio_r;
   wire nmi_s;
   wire [3:0] irl_s;
   wire [NPIN-1:0] pin_s;
   reg nmi_d_r;
   reg nmi_pend_r;
   wire bl = sr_r[`IAU_SR_BL];
   wire [3:0] priority_mask_field = sr_r[`IAU_SR_IM_HI:`IAU_SR_IM_LO];
   wire sleep = ctl_r[`IAU_CTL_SLEEP];
   wire [3:0] irl_lvl = irl_s;

   iau_sync #(.W(1 + 4 + NPIN)) u_sync (
      .clk(REF_CLK),
      .rst_n(RESETN),
      // level inverted ahead of the flops so reset reads as no request
      .d({NMI_PIN, ~IRL_N, PIN_REQ}),
      .q({nmi_s, irl_s, pin_s})
   );

   // request vector: irl, pins, modules
   wire [NM-1:0] req_v;
   wire [4*NM-1:0] lvl_v;
   wire [12*NM-1:0] code_v;
   wire [NM-1:0] elig;
   assign req_v = {MOD_REQ, pin_s, (irl_lvl != 4'h0)};
   assign lvl_v = {prio_r, pprio_r, irl_lvl};
   assign code_v = {MOD_CODE, PIN_CODE, `IAU_CODE_IRL_BASE + {3'h0, irl_lvl, 5'h00}};
   genvar g;
   generate
      for (g = 0; g < NM; g = g + 1)
      begin : g_elig
         // level above mask
         assign elig[g] = req_v[g] && (lvl_v[4*g +: 4] > priority_mask_field);
      end
   endgenerate

   wire hit;
   wire [3:0] win_lvl;
   wire [11:0] win_code;
   wire [$clog2(NM+1)-1:0] win_idx;
   iau_arbiter #(.N(NM)) u_arb (
      .req(elig),
      .lvl(lvl_v),
      .code(code_v),
      .hit(hit),
      .win_lvl(win_lvl),
      .win_code(win_code),
      .win_idx(win_idx)
   );

   // held while bl, unless sleeping
   wire open = !bl || sleep;
   // nmi: mask-free, top priority, override under hold
   wire nmi_go = nmi_pend_r && (open || ctl_r[`IAU_CTL_OVR]);
   wire int_go = BOUNDARY && hit && open && !nmi_go;
   wire is_pin = (win_idx >= 1) && (win_idx <= NPIN);
   // breaks dropped under hold
   wire exc_go = EXC_REQ && !(EXC_UBRK && bl);
   // saved pc choice
   wire [31:0] exc_spc = EXC_REEXEC ? (IN_SLOT ? (BR_TAKEN ? BR_PC : CUR_PC) : CUR_PC)
                                    : (IN_SLOT ? (BR_TAKEN ? BR_TGT : NEXT_PC) : NEXT_PC);
   wire [31:0] sr_ent = sr_r | (32'h1 << `IAU_SR_MD) | (32'h1 << `IAU_SR_RB) | (32'h1 << `IAU_SR_BL);

   // axi state
   reg aw_got_r;
   reg w_got_r;
   reg [11:0] aw_r;
   reg [31:0] wd_r;
   reg [3:0] ws_r;
   wire wr_do = aw_got_r && w_got_r && !BVALID;
   wire [31:0] wmask = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}}, {8{ws_r[0]}}};
   reg wr_ok;
   always @*
   begin
      wr_ok = 1'b1;
      if (aw_r == `IAU_A_SR) wr_ok = 1'b1;
      else if (aw_r == `IAU_A_VBR) wr_ok = 1'b1;
      else if (aw_r == `IAU_A_SPC) wr_ok = 1'b1;
      else if (aw_r == `IAU_A_SSR) wr_ok = 1'b1;
      else if (aw_r == `IAU_A_CTL) wr_ok = 1'b1;
      else if (aw_r == `IAU_A_PRIO) wr_ok = 1'b1;
      else wr_ok = 1'b0;
   end

   // nmi edge latch; set wins over take
   always @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         nmi_d_r <= 1'b0;
         nmi_pend_r <= 1'b0;
      end
      else
      begin
         nmi_d_r <= nmi_s;
         if (nmi_s && !nmi_d_r)
            nmi_pend_r <= 1'b1;
         else if (nmi_go)
            nmi_pend_r <= 1'b0;
      end
   end

   // reset-initialised state
   always @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         sr_r <= `IAU_SR_RST;
         vbr_r <= `IAU_VBR_RST;
         exp_r <= `IAU_CODE_POR;
         evt_r <= 12'h000;
         evt2_r <= 12'h000;
         ctl_r <= 2'h0;
         prio_r <= {4*NMOD{1'b0}};
         pprio_r <= {4*NPIN{1'b0}};
         TAKE <= 1'b0;
         NEW_PC <= `IAU_RESET_PC;
         SR_OUT <= `IAU_SR_RST;
      end
      else
      begin
         TAKE <= 1'b0;
         if (nmi_go)
         begin
            evt_r <= `IAU_CODE_NMI;
            sr_r <= sr_ent;
            TAKE <= 1'b1;
            NEW_PC <= vbr_r + `IAU_VEC_INT;
            SR_OUT <= sr_ent;
         end
         else if (int_go)
         begin
            // mask field untouched
            evt_r <= win_code;
            if (is_pin)
               evt2_r <= win_code;
            sr_r <= sr_ent;
            TAKE <= 1'b1;
            NEW_PC <= vbr_r + `IAU_VEC_INT;
            SR_OUT <= sr_ent;
         end
         else if (exc_go)
         begin
            TAKE <= 1'b1;
            if (bl)
               NEW_PC <= `IAU_RESET_PC;
            else
            begin
               exp_r <= EXC_CODE;
               sr_r <= sr_ent;
               NEW_PC <= vbr_r + `IAU_VEC_GEN;
               SR_OUT <= sr_ent;
            end
         end
         else if (RET_REQ)
         begin
            sr_r <= ssr_r;
            TAKE <= 1'b1;
            NEW_PC <= spc_r;
            SR_OUT <= ssr_r;
         end
         else if (wr_do && wr_ok)
         begin
            if (aw_r == `IAU_A_SR)
            begin
               sr_r <= (sr_r & ~wmask) | (wd_r & wmask);
               SR_OUT <= (sr_r & ~wmask) | (wd_r & wmask);
            end
            else if (aw_r == `IAU_A_VBR)
               vbr_r <= (vbr_r & ~wmask) | (wd_r & wmask);
            else if (aw_r == `IAU_A_CTL)
            begin
               if (ws_r[0]) ctl_r <= wd_r[1:0];
            end
            else if (aw_r == `IAU_A_PRIO)
            begin
               prio_r <= wd_r[4*NMOD-1:0];
               pprio_r <= wd_r[4*NMOD +: 4*NPIN];
            end
         end
      end
   end

   // saved copies have no reset
   always @(posedge REF_CLK)
   begin
      if (nmi_go || int_go)
      begin
         spc_r <= NEXT_PC;
         ssr_r <= sr_r;
      end
      else if (exc_go && !bl)
      begin
         spc_r <= exc_spc;
         ssr_r <= sr_r;
      end
      else if (!RET_REQ && wr_do && aw_r == `IAU_A_SPC)
         spc_r <= (spc_r & ~wmask) | (wd_r & wmask);
      else if (!RET_REQ && wr_do && aw_r == `IAU_A_SSR)
         ssr_r <= (ssr_r & ~wmask) | (wd_r & wmask);
   end

   // axi write channels
   always @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         aw_r <= 12'h000;
         wd_r <= 32'h00000000;
         ws_r <= 4'h0;
         AWREADY <= 1'b1;
         WREADY <= 1'b1;
         BVALID <= 1'b0;
         BRESP <= 2'h0;
      end
      else
      begin
         if (AWVALID && AWREADY)
         begin
            aw_r <= AWADDR;
            aw_got_r <= 1'b1;
            AWREADY <= 1'b0;
         end
         if (WVALID && WREADY)
         begin
            wd_r <= WDATA;
            ws_r <= WSTRB;
            w_got_r <= 1'b1;
            WREADY <= 1'b0;
         end
         if (wr_do && !(nmi_go || int_go || exc_go || RET_REQ))
         begin
            BVALID <= 1'b1;
            BRESP <= wr_ok ? 2'h0 : 2'h2;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
         end
         if (BVALID && BREADY)
         begin
            BVALID <= 1'b0;
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
         end
      end
   end

   // axi read channel
   always @(posedge REF_CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         ARREADY <= 1'b1;
         RVALID <= 1'b0;
         RDATA <= 32'h00000000;
         RRESP <= 2'h0;
      end
      else
      begin
         if (ARVALID && ARREADY)
         begin
            ARREADY <= 1'b0;
            RVALID <= 1'b1;
            RRESP <= 2'h0;
            if (ARADDR == `IAU_A_SR) RDATA <= sr_r;
            else if (ARADDR == `IAU_A_VBR) RDATA <= vbr_r;
            else if (ARADDR == `IAU_A_SPC) RDATA <= spc_r;
            else if (ARADDR == `IAU_A_SSR) RDATA <= ssr_r;
            else if (ARADDR == `IAU_A_EVT) RDATA <= {20'h00000, evt_r};
            else if (ARADDR == `IAU_A_EVT2) RDATA <= {20'h00000, evt2_r};
            else if (ARADDR == `IAU_A_EXP) RDATA <= {20'h00000, exp_r};
            else if (ARADDR == `IAU_A_CTL) RDATA <= {30'h00000000, ctl_r};
            else if (ARADDR == `IAU_A_PRIO)
               RDATA <= {{(32-4*NMOD-4*NPIN){1'b0}}, pprio_r, prio_r};
            else if (ARADDR == `IAU_A_PC) RDATA <= NEW_PC;
            else
            begin
               RDATA <= 32'h00000000;
               RRESP <= 2'h2;
            end
         end
         else if (RVALID && RREADY)
         begin
            RVALID <= 1'b0;
            ARREADY <= 1'b1;
         end
      end
   end
endmodule

// ==== dv/iau_top_asserts.sv ====
`timescale 1ns/100ps
module iau_chk (
   // clock and reset
   input wire REF_CLK,
   input wire RESETN,
   // event port
   input wire EXC_REQ,
   input wire EXC_UBRK,
   input wire RET_REQ,
   input wire TAKE,
   input wire [31:0] NEW_PC,
   input wire [31:0] SR_OUT,
   // register bus
   input wire AWVALID,
   input wire AWREADY,
   input wire WVALID,
   input wire WREADY,
   input wire BVALID,
   input wire BREADY,
   input wire ARVALID,
   input wire ARREADY,
   input wire RVALID,
   input wire RREADY,
   input wire [31:0] RDATA
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESETN);
   rst_vals_a: assert property ($rose(RESETN) |-> NEW_PC == 32'hA0000000 && SR_OUT == 32'h700000F0)
      else $error("reset state wrong");
   entry_bits_a: assert property (TAKE && !$past(RET_REQ) && !$past(EXC_REQ) |-> SR_OUT[30:28] == 3'h7)
      else $error("entry control bits not set");
   ret_take_a: assert property (RET_REQ |=> TAKE)
      else $error("return not taken");
   exc_take_a: assert property (EXC_REQ && !EXC_UBRK |=> TAKE)
      else $error("exception not taken");
   w_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:8] BVALID)
      else $error("write not answered");
   r_answer_a: assert property (ARVALID && ARREADY |-> ##[1:4] RVALID)
      else $error("read not answered");
   b_hold_a: assert property (BVALID && !BREADY |=> BVALID)
      else $error("write response dropped");
   r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read response dropped");
endmodule

// ==== dv/iau_src_model.sv ====
`timescale 1ns/100ps
// request sources: copy the testbench request levels onto their lines one clock later
module iau_src_model (
   input wire clk,
   input wire [3:0] lvl,
   input wire nmi,
   input wire [1:0] pin,
   input wire [3:0] md,
   output reg nmi_pin,
   output reg [3:0] irl_n,
   output reg [1:0] pin_req,
   output reg [3:0] mod_req,
   output wire [23:0] pin_code,
   output wire [47:0] mod_code
);
   assign pin_code = {12'h620, 12'h600};
   assign mod_code = {12'h460, 12'h440, 12'h420, 12'h400};
   // idle lines
   initial {nmi_pin, irl_n, pin_req, mod_req} = 11'h3C0;
   always @(posedge clk)
   begin
      nmi_pin <= nmi;
      irl_n <= ~lvl;
      pin_req <= pin;
      mod_req <= md;
   end
endmodule

// ==== dv/iau_top_tb_top.sv ====
`timescale 1ns/100ps
`include "iau_defs.vh"
`define CK(n, e, s) begin check_count++; if ((s) !== (e)) begin failures++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module iau_top_tb_top;
   logic clk = 0, rstn = 0, bnd = 0, slot = 0, btk = 0, exq = 0, rex = 0, ubk = 0, ret = 0, nmi = 0;
   logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [11:0] ecode = 12'h000, aw = 12'h000, ar = 12'h000;
   logic [31:0] wd = 32'h0;
   logic [3:0] lvl = 4'h0, md = 4'h0;
   logic [1:0] pin = 2'h0;
   wire nmi_pin, take, awr, wrr, bv, arr, rv;
   wire [3:0] irl_n, mod_req;
   wire [1:0] pin_req, br, rr;
   wire [23:0] pcd;
   wire [47:0] mcd;
   wire [31:0] npc, sro, rdat;
   int failures = 0, check_count = 0;
   iau_src_model u_src (.clk(clk), .lvl(lvl), .nmi(nmi), .pin(pin), .md(md), .nmi_pin(nmi_pin), .irl_n(irl_n),
      .pin_req(pin_req), .mod_req(mod_req), .pin_code(pcd), .mod_code(mcd));
   iau_top u_dut (.REF_CLK(clk), .RESETN(rstn), .NMI_PIN(nmi_pin), .IRL_N(irl_n), .PIN_REQ(pin_req),
      .MOD_REQ(mod_req), .PIN_CODE(pcd), .MOD_CODE(mcd), .BOUNDARY(bnd), .NEXT_PC(32'h00000100),
      .CUR_PC(32'h000000FE), .BR_PC(32'h000000F0), .BR_TGT(32'h00000300), .IN_SLOT(slot), .BR_TAKEN(btk),
      .EXC_REQ(exq), .EXC_REEXEC(rex), .EXC_UBRK(ubk), .EXC_CODE(ecode), .RET_REQ(ret), .TAKE(take),
      .NEW_PC(npc), .SR_OUT(sro), .AWADDR(aw), .AWVALID(awv), .AWREADY(awr), .WDATA(wd), .WSTRB(4'hF),
      .WVALID(wv), .WREADY(wrr), .BRESP(br), .BVALID(bv), .BREADY(bry), .ARADDR(ar), .ARVALID(arv),
      .ARREADY(arr), .RDATA(rdat), .RRESP(rr), .RVALID(rv), .RREADY(rry));
   initial forever #5 clk = ~clk;
   task tally_and_finish;
      if (failures == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
      aw <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wrr) wv <= 1'b0;
      end
      while (awv || wv);
      do @(posedge clk); while (bv !== 1'b1);
      bry <= 1'b1;
      @(posedge clk);
      bry <= 1'b0;
      `CK("bresp", e, br)
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      ar <= a;
      arv <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (rv !== 1'b1);
      rry <= 1'b1;
      @(posedge clk);
      rry <= 1'b0;
      `CK("rresp", er, rr)
      if (er == 2'h0) `CK("rdata", e, rdat)
   endtask
   // v = {boundary, exception, user break, return, expect redirect}
   task go(input logic [4:0] v, input logic [31:0] pc);
      {bnd, exq, ubk, ret} <= v[4:1];
      @(posedge clk);
      {bnd, exq, ubk, ret} <= 4'h0;
      #1;
      `CK("take", v[0], take)
      if (v[0]) `CK("new_pc", pc, npc)
      @(posedge clk);
   endtask
   task irq(input logic [3:0] m, input logic [1:0] p, input logic [11:0] c, input logic [11:0] c2);
      md <= m;
      pin <= p;
      wr(`IAU_A_SR, 32'h60000020, 2'h0);
      repeat (4) @(posedge clk);
      go(5'b10001, 32'h00001600);
      rd(`IAU_A_EVT, {20'h0, c}, 2'h0);
      rd(`IAU_A_EVT2, {20'h0, c2}, 2'h0);
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      `CK("new_pc", 32'hA0000000, npc)
      rd(`IAU_A_SR, 32'h700000F0, 2'h0);
      rd(`IAU_A_VBR, 32'h0, 2'h0);
      rd(`IAU_A_EXP, 32'h0, 2'h0);
      rd(12'h040, 32'h0, 2'h2);
      wr(`IAU_A_EVT, 32'h0, 2'h2);
      ecode <= 12'h1A0;
      go(5'b01100, 32'h0);
      go(5'b01001, 32'hA0000000);
      wr(`IAU_A_VBR, 32'h00001000, 2'h0);
      lvl <= 4'h5;
      wr(`IAU_A_SR, 32'h600000F0, 2'h0);
      repeat (4) @(posedge clk);
      go(5'b10000, 32'h0);
      wr(`IAU_A_SR, 32'h60000040, 2'h0);
      go(5'b10001, 32'h00001600);
      rd(`IAU_A_EVT, 32'h2A0, 2'h0);
      rd(`IAU_A_SR, 32'h70000040, 2'h0);
      rd(`IAU_A_SPC, 32'h100, 2'h0);
      rd(`IAU_A_SSR, 32'h60000040, 2'h0);
      go(5'b10000, 32'h0);
      lvl <= 4'h0;
      wr(`IAU_A_PRIO, 32'h00761293, 2'h0);
      irq(4'h0, 2'h3, 12'h620, 12'h620);
      irq(4'h0, 2'h1, 12'h600, 12'h600);
      irq(4'h2, 2'h3, 12'h420, 12'h600);
      md <= 4'h1;
      pin <= 2'h0;
      wr(`IAU_A_SR, 32'h70000000, 2'h0);
      wr(`IAU_A_CTL, 32'h2, 2'h0);
      repeat (2) @(posedge clk);
      go(5'b10001, 32'h00001600);
      md <= 4'h0;
      wr(`IAU_A_CTL, 32'h0, 2'h0);
      wr(`IAU_A_SPC, 32'h12345678, 2'h0);
      wr(`IAU_A_SSR, 32'h600000A0, 2'h0);
      go(5'b00011, 32'h12345678);
      `CK("sr_out", 32'h600000A0, sro)
      {slot, btk, rex} <= 3'h7;
      go(5'b01001, 32'h00001100);
      rd(`IAU_A_SPC, 32'hF0, 2'h0);
      rd(`IAU_A_EXP, 32'h1A0, 2'h0);
      rex <= 1'b0;
      wr(`IAU_A_SR, 32'h600000A0, 2'h0);
      go(5'b01001, 32'h00001100);
      rd(`IAU_A_SPC, 32'h300, 2'h0);
      wr(`IAU_A_SR, 32'h600000F0, 2'h0);
      nmi <= 1'b1;
      repeat (3) @(posedge clk);
      nmi <= 1'b0;
      for (int i = 0; i < 20 && take !== 1'b1; i++) @(posedge clk);
      `CK("nmi_pc", 32'h00001600, npc)
      rd(`IAU_A_EVT, 32'h1C0, 2'h0);
      nmi <= 1'b1;
      repeat (3) @(posedge clk);
      nmi <= 1'b0;
      repeat (8)
      begin
         @(posedge clk);
         `CK("no_take", 1'b0, take)
      end
      wr(`IAU_A_VBR, 32'h00002000, 2'h0);
      wr(`IAU_A_CTL, 32'h1, 2'h0);
      repeat (4) @(posedge clk);
      `CK("nmi_pc", 32'h00002600, npc)
      tally_and_finish;
   end
   initial
   begin
      #100000;
      failures++;
      tally_and_finish;
   end
endmodule
bind iau_top iau_chk u_chk (.REF_CLK(REF_CLK), .RESETN(RESETN), .EXC_REQ(EXC_REQ), .EXC_UBRK(EXC_UBRK),
   .RET_REQ(RET_REQ), .TAKE(TAKE), .NEW_PC(NEW_PC), .SR_OUT(SR_OUT), .AWVALID(AWVALID), .AWREADY(AWREADY),
   .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
   .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA));
